// [hw/smt_ctrl.sv]
// control, status and source selection of the signal measurement timer,
// with an axi4-lite register slave and one level interrupt.
// assumes all source inputs are asynchronous and far slower than clk.
// Contract
// - repeat bit: continuous, else single acquisition
// - mode field selects eleven modes, rest reserved
// - period request copies counter, then self-clears
// - pulse request copies counter, then self-clears
// - reset request clears counter, then self-clears
// - status bit 2 shows counter incrementing
// - status bit 1 shows window open
// - status bit 0 shows acquisition in progress
// - clock select picks counter clock, reserved codes
// - only clock codes 2..7 run in sleep
// - window select routes window input, reserved codes
// - only window codes 1..4 run in sleep
// - signal select routes signal input, reserved codes
// - go enables counting and acquisition
`timescale 1ns/1ps

module smt_ctrl (
  input  wire logic                         clk,
  input  wire logic                         rst,
  // raw source inputs, asynchronous
  input  wire logic [smt_pkg::CLK_SRC_N-1:0] clockSources,
  input  wire logic [smt_pkg::WIN_SRC_N-1:0] windowSources,
  input  wire logic [smt_pkg::SIG_SRC_N-1:0] signalSources,
  input  wire logic                         sleepMode,
  // axi4-lite slave
  input  wire logic [11:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [11:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // results
  output logic [23:0]                       measureCounter,
  output logic [23:0]                       periodCapture,
  output logic [23:0]                       pulseWidthCapture,
  output logic                              countingFlag,
  output logic                              windowOpenFlag,
  output logic                              acquisitionActiveFlag,
  output logic                              irq
);

  smt_pkg::smt_state_t q;  // registered state
  smt_pkg::smt_state_t d;  // next state

  //////////////////////////////////////////////////////////////////////////////
  // source selection helpers

  // pick the counter clock; reserved codes read low
  function automatic logic pickClock(input logic [3:0] sel,
                                     input logic [smt_pkg::CLK_SRC_N-1:0] src,
                                     input logic sleep);
    logic v;
    v = 1'b0;
    if (sel < 4'(smt_pkg::CLK_SRC_N)) begin
      v = src[sel];
    end
    if (sleep && !(sel >= smt_pkg::CLK_SLEEP_LO && sel <= smt_pkg::CLK_SLEEP_HI)) begin
      v = 1'b0;
    end
    return v;
  endfunction : pickClock

  // pick the window input; reserved codes read low
  function automatic logic pickWindow(input logic [4:0] sel,
                                      input logic [smt_pkg::WIN_SRC_N-1:0] src,
                                      input logic sleep);
    logic v;
    v = 1'b0;
    if (sel < 5'(smt_pkg::WIN_SRC_N)) begin
      v = src[sel];
    end
    if (sleep && !(sel >= smt_pkg::WIN_SLEEP_LO && sel <= smt_pkg::WIN_SLEEP_HI)) begin
      v = 1'b0;
    end
    return v;
  endfunction : pickWindow

  // pick the signal input; no signal source survives sleep
  function automatic logic pickSignal(input logic [4:0] sel,
                                      input logic [smt_pkg::SIG_SRC_N-1:0] src,
                                      input logic sleep);
    logic v;
    v = 1'b0;
    if (sel < 5'(smt_pkg::SIG_SRC_N) && !sleep) begin
      v = src[sel];
    end
    return v;
  endfunction : pickSignal

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic       clkNow;
    logic       winNow;
    logic       sigNow;
    logic       clkRise;
    logic       sigRise;
    logic       winRise;
    logic       winFall;
    logic       modeOk;
    logic       gated;
    logic       tick;
    logic       capPer;
    logic       capPw;
    logic       clrCnt;
    logic       enable;
    logic       doWrite;
    logic [9:0] wIdx;
    logic [9:0] rIdx;
    logic [7:0] wb;
    logic [smt_pkg::EVT_W-1:0] evt;
    d       = q;
    clkNow  = 1'b0;
    winNow  = 1'b0;
    sigNow  = 1'b0;
    clkRise = 1'b0;
    sigRise = 1'b0;
    winRise = 1'b0;
    winFall = 1'b0;
    modeOk  = 1'b0;
    gated   = 1'b0;
    tick    = 1'b0;
    capPer  = 1'b0;
    capPw   = 1'b0;
    clrCnt  = 1'b0;
    enable  = 1'b0;
    doWrite = 1'b0;
    wIdx    = q.awAddr[11:2];
    rIdx    = s_axi_araddr[11:2];
    wb      = q.wData[7:0];
    evt     = '0;

    // two-stage synchronisers; only stage two is read by logic
    d.s1.clk   = clockSources;
    d.s1.win   = windowSources;
    d.s1.sig   = signalSources;
    d.s1.sleep = sleepMode;
    d.s2       = q.s1;

    // selected sources and their edges
    clkNow  = pickClock(q.clkSel, q.s2.clk, q.s2.sleep);
    winNow  = pickWindow(q.winSel, q.s2.win, q.s2.sleep);
    sigNow  = pickSignal(q.sigSel, q.s2.sig, q.s2.sleep);
    d.clkPrev = clkNow;
    d.winPrev = winNow;
    d.sigPrev = sigNow;
    clkRise = clkNow & ~q.clkPrev;
    sigRise = sigNow & ~q.sigPrev;
    winRise = winNow & ~q.winPrev;
    winFall = ~winNow & q.winPrev;

    // mode decode; reserved modes never count or capture
    modeOk = (q.mode <= smt_pkg::MODE_WIN_CNT);
    case (q.mode)
      smt_pkg::MODE_GATED_TIMER,
      smt_pkg::MODE_GATED_WIN,
      smt_pkg::MODE_GATED_CNT: begin
        gated = 1'b1;  // count only while window is high
      end
      default: begin
        gated = 1'b0;
      end
    endcase
    // go enables both counting and capture; single mode stops after one
    enable = q.go & modeOk & ~q.acqDone;
    if (q.mode >= smt_pkg::MODE_COUNTER) begin
      tick = sigRise;  // counter modes count signal edges
    end else begin
      tick = clkRise;  // timer modes count clock edges
    end
    if (gated && !winNow) begin
      tick = 1'b0;
    end

    // hardware capture events per mode
    case (q.mode)
      smt_pkg::MODE_PERIOD_DUTY,
      smt_pkg::MODE_HIGH_LOW,
      smt_pkg::MODE_WINDOWED,
      smt_pkg::MODE_GATED_WIN,
      smt_pkg::MODE_WIN_CNT: begin
        capPer = winRise;
        clrCnt = winRise;
        capPw  = winFall & (q.mode != smt_pkg::MODE_WINDOWED);
      end
      smt_pkg::MODE_TOF: begin
        capPer = sigRise;
        clrCnt = sigRise;
      end
      smt_pkg::MODE_CAPTURE: begin
        capPer = winRise;  // timer keeps running in capture mode
        capPw  = winFall;
      end
      smt_pkg::MODE_COUNTER,
      smt_pkg::MODE_GATED_CNT: begin
        capPw  = winFall;
      end
      default: begin
        capPer = 1'b0;
      end
    endcase
    capPer = capPer & enable;
    capPw  = capPw & enable;
    clrCnt = clrCnt & enable;

    // counter update; reset request has priority
    if (q.reqReset) begin
      d.counter  = smt_pkg::RST_COUNT;
      d.reqReset = 1'b0;                // completes in one cycle
    end else if (clrCnt) begin
      d.counter = smt_pkg::RST_COUNT;
    end else if (enable && tick) begin
      d.counter = q.counter + 24'h000001;
    end

    // capture registers, manual or hardware
    if (q.reqPeriod || capPer) begin
      d.periodCap = q.counter;
      d.reqPeriod = 1'b0;
      evt[smt_pkg::EVT_PERIOD] = 1'b1;
    end
    if (q.reqPulse || capPw) begin
      d.pulseCap = q.counter;
      d.reqPulse = 1'b0;
      evt[smt_pkg::EVT_PULSE] = 1'b1;
    end
    // a single acquisition ends at its first period capture
    if (capPer && !q.repeatAcq) begin
      d.acqDone = 1'b1;
      evt[smt_pkg::EVT_DONE] = 1'b1;
    end
    if (!q.go) begin
      d.acqDone = 1'b0;  // rearm for the next go
    end

    // status flags
    d.counting  = enable & tick;
    d.winOpen   = winNow;
    d.acqActive = enable;

    //////////////////////////////////////////////////////////////////////////
    // axi write: address and data taken in either order
    if (s_axi_awvalid && !q.awHave && !q.bValid) begin
      d.awHave = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHave && !q.bValid) begin
      d.wHave  = 1'b1;
      d.wData  = s_axi_wdata;
      d.wStrb0 = s_axi_wstrb[0];
    end
    doWrite = q.awHave & q.wHave & ~q.bValid;
    if (doWrite) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = smt_pkg::RESP_OKAY;
      case (wIdx)
        smt_pkg::IDX_CONTROL_B: begin
          if (q.wStrb0) begin
            d.go        = wb[smt_pkg::CTL_GO_BIT];
            d.repeatAcq = wb[smt_pkg::CTL_REPEAT_BIT];
            d.mode      = wb[3:0];
          end
        end
        smt_pkg::IDX_STATUS: begin
          if (q.wStrb0) begin
            d.reqPeriod = wb[smt_pkg::STA_PERIOD_BIT];
            d.reqPulse  = wb[smt_pkg::STA_PULSE_BIT];
            d.reqReset  = wb[smt_pkg::STA_RESET_BIT];
          end
        end
        smt_pkg::IDX_CLOCK_SEL: begin
          if (q.wStrb0) begin
            d.clkSel = wb[3:0];
          end
        end
        smt_pkg::IDX_SIGNAL_SEL: begin
          if (q.wStrb0) begin
            d.sigSel = wb[4:0];
          end
        end
        smt_pkg::IDX_WINDOW_SEL: begin
          if (q.wStrb0) begin
            d.winSel = wb[4:0];
          end
        end
        smt_pkg::IDX_IRQ_STATUS: begin
          if (q.wStrb0) begin
            d.irqStat = q.irqStat & ~wb[smt_pkg::EVT_W-1:0];  // write one clears
          end
        end
        smt_pkg::IDX_IRQ_MASK: begin
          if (q.wStrb0) begin
            d.irqMask = wb[smt_pkg::EVT_W-1:0];
          end
        end
        smt_pkg::IDX_PERIOD_CAP,
        smt_pkg::IDX_PULSE_CAP,
        smt_pkg::IDX_COUNTER: begin
          d.bResp = smt_pkg::RESP_OKAY;  // read only, write ignored
        end
        default: begin
          d.bResp = smt_pkg::RESP_SLVERR;  // unmapped
        end
      endcase
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end

    // sticky events; a new event beats a same-cycle clear
    d.irqStat = d.irqStat | evt;
    d.irq     = |(d.irqStat & d.irqMask);

    //////////////////////////////////////////////////////////////////////////
    // axi read: one beat, answered the cycle after the address
    if (s_axi_arvalid && !q.rValid) begin
      d.rValid = 1'b1;
      d.rResp  = smt_pkg::RESP_OKAY;
      d.rData  = '0;
      case (rIdx)
        smt_pkg::IDX_CONTROL_B: begin
          d.rData[smt_pkg::CTL_GO_BIT]     = q.go;
          d.rData[smt_pkg::CTL_REPEAT_BIT] = q.repeatAcq;
          d.rData[3:0]                     = q.mode;
        end
        smt_pkg::IDX_STATUS: begin
          d.rData[smt_pkg::STA_PERIOD_BIT] = q.reqPeriod;
          d.rData[smt_pkg::STA_PULSE_BIT]  = q.reqPulse;
          d.rData[smt_pkg::STA_RESET_BIT]  = q.reqReset;
          d.rData[smt_pkg::STA_COUNT_BIT]  = q.counting;
          d.rData[smt_pkg::STA_WINDOW_BIT] = q.winOpen;
          d.rData[smt_pkg::STA_ACQ_BIT]    = q.acqActive;
        end
        smt_pkg::IDX_CLOCK_SEL: begin
          d.rData[3:0] = q.clkSel;
        end
        smt_pkg::IDX_SIGNAL_SEL: begin
          d.rData[4:0] = q.sigSel;
        end
        smt_pkg::IDX_WINDOW_SEL: begin
          d.rData[4:0] = q.winSel;
        end
        smt_pkg::IDX_IRQ_STATUS: begin
          d.rData[smt_pkg::EVT_W-1:0] = q.irqStat;
        end
        smt_pkg::IDX_IRQ_MASK: begin
          d.rData[smt_pkg::EVT_W-1:0] = q.irqMask;
        end
        smt_pkg::IDX_PERIOD_CAP: begin
          d.rData[23:0] = q.periodCap;
        end
        smt_pkg::IDX_PULSE_CAP: begin
          d.rData[23:0] = q.pulseCap;
        end
        smt_pkg::IDX_COUNTER: begin
          d.rData[23:0] = q.counter;
        end
        default: begin
          d.rResp = smt_pkg::RESP_SLVERR;  // unmapped reads zero
        end
      endcase
    end else if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;  // all control, selectors and flags clear
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign s_axi_awready         = ~q.awHave & ~q.bValid;
  assign s_axi_wready          = ~q.wHave & ~q.bValid;
  assign s_axi_bvalid          = q.bValid;
  assign s_axi_bresp           = q.bResp;
  assign s_axi_arready         = ~q.rValid;
  assign s_axi_rvalid          = q.rValid;
  assign s_axi_rdata           = q.rData;
  assign s_axi_rresp           = q.rResp;
  assign measureCounter        = q.counter;
  assign periodCapture         = q.periodCap;
  assign pulseWidthCapture     = q.pulseCap;
  assign countingFlag          = q.counting;
  assign windowOpenFlag        = q.winOpen;
  assign acquisitionActiveFlag = q.acqActive;
  assign irq                   = q.irq;

endmodule : smt_ctrl

// [hw/smt_pkg.sv]
// package of the measurement timer control block: register map, field layout,
// reset values, mode codes and the carrier types shared by the design.
// assumes a 12-bit byte address on the register bus and 32-bit data.
package smt_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CONTROL_B   = 10'h30d;  // measure_control_b
  localparam logic [9:0]  IDX_STATUS      = 10'h30e;  // measure_status
  localparam logic [9:0]  IDX_CLOCK_SEL   = 10'h30f;  // clock_source_select
  localparam logic [9:0]  IDX_SIGNAL_SEL  = 10'h310;  // signal_source_select
  localparam logic [9:0]  IDX_WINDOW_SEL  = 10'h311;  // window_source_select
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h320;  // sticky event flags
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h321;  // event enables
  localparam logic [9:0]  IDX_PERIOD_CAP  = 10'h322;  // period_capture, read only
  localparam logic [9:0]  IDX_PULSE_CAP   = 10'h323;  // pulse_width_capture, read only
  localparam logic [9:0]  IDX_COUNTER     = 10'h324;  // measure_counter, read only

  // field positions
  localparam int CTL_GO_BIT      = 7;
  localparam int CTL_REPEAT_BIT  = 6;
  localparam int STA_PERIOD_BIT  = 7;
  localparam int STA_PULSE_BIT   = 6;
  localparam int STA_RESET_BIT   = 4;
  localparam int STA_COUNT_BIT   = 2;
  localparam int STA_WINDOW_BIT  = 1;
  localparam int STA_ACQ_BIT     = 0;

  // event bits of the interrupt status and mask
  localparam int EVT_PERIOD      = 0;
  localparam int EVT_PULSE       = 1;
  localparam int EVT_DONE        = 2;
  localparam int EVT_W           = 3;

  // source counts and selector limits
  localparam int CLK_SRC_N       = 9;
  localparam int WIN_SRC_N       = 24;
  localparam int SIG_SRC_N       = 21;
  localparam logic [3:0] CLK_SLEEP_LO = 4'h2;
  localparam logic [3:0] CLK_SLEEP_HI = 4'h7;
  localparam logic [4:0] WIN_SLEEP_LO = 5'h01;
  localparam logic [4:0] WIN_SLEEP_HI = 5'h04;

  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [23:0] RST_COUNT = 24'h000000;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes; 4'hb upward reserved
  typedef enum logic [3:0] {
    MODE_TIMER       = 4'h0,
    MODE_GATED_TIMER = 4'h1,
    MODE_PERIOD_DUTY = 4'h2,
    MODE_HIGH_LOW    = 4'h3,
    MODE_WINDOWED    = 4'h4,
    MODE_GATED_WIN   = 4'h5,
    MODE_TOF         = 4'h6,
    MODE_CAPTURE     = 4'h7,
    MODE_COUNTER     = 4'h8,
    MODE_GATED_CNT   = 4'h9,
    MODE_WIN_CNT     = 4'ha
  } smt_mode_t;

  // synchronised source inputs travelling together
  typedef struct packed {
    logic [CLK_SRC_N-1:0] clk;
    logic [WIN_SRC_N-1:0] win;
    logic [SIG_SRC_N-1:0] sig;
    logic                 sleep;
  } smt_src_t;

  // whole state of the block
  typedef struct packed {
    smt_src_t    s1;          // first synchroniser stage
    smt_src_t    s2;          // second synchroniser stage
    logic        go;
    logic        repeatAcq;
    logic [3:0]  mode;
    logic        reqPeriod;
    logic        reqPulse;
    logic        reqReset;
    logic [3:0]  clkSel;
    logic [4:0]  sigSel;
    logic [4:0]  winSel;
    logic [EVT_W-1:0] irqStat;
    logic [EVT_W-1:0] irqMask;
    logic [23:0] counter;
    logic [23:0] periodCap;
    logic [23:0] pulseCap;
    logic        acqDone;
    logic        counting;
    logic        winOpen;
    logic        acqActive;
    logic        clkPrev;
    logic        sigPrev;
    logic        winPrev;
    logic        awHave;
    logic [11:0] awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic        wStrb0;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic        irq;
  } smt_state_t;

endpackage : smt_pkg

// [tb/smt_ctrl_chk.sv]
// checker of the measurement timer control block: bus answer timing and the
// relations between counter, captures and the counting flag.
// assumes one clock and the synchronous active-high reset of the design.
`timescale 1ns/1ps

module smt_ctrl_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [23:0] measureCounter,
  input wire logic [23:0] periodCapture,
  input wire logic [23:0] pulseWidthCapture,
  input wire logic        countingFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // write: both channels taken on one edge, answer two edges later
  sequence sWrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sWrAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_wr_answer:
    assert property (sWrTake |=> sWrAnswer) else $error("write answer off time");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer off time");
  // readies come back right after the answer is taken
  a_wr_reopen:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
      && s_axi_wready) else $error("write side not reopened");
  a_rd_reopen:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read side not reopened");
  // no new request taken while an answer is pending
  a_wr_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");

  ////////////////////////////////////////////////////////////////////////////////
  // counter only steps by one or clears; never jumps
  a_cnt_step:
    assert property ($changed(measureCounter) |-> measureCounter == 24'h000000
      || measureCounter == $past(measureCounter) + 24'h000001)
    else $error("counter jumped");
  a_cnt_flag:
    assert property (measureCounter == $past(measureCounter) + 24'h000001 |-> countingFlag)
    else $error("counting flag missed a tick");
  // captures only ever take the counter value
  a_per_copy:
    assert property ($changed(periodCapture) |-> periodCapture == $past(measureCounter))
    else $error("period capture not from counter");
  a_pul_copy:
    assert property ($changed(pulseWidthCapture)
      |-> pulseWidthCapture == $past(measureCounter))
    else $error("pulse capture not from counter");
endmodule : smt_ctrl_chk

bind smt_ctrl smt_ctrl_chk chk_u (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .measureCounter(measureCounter), .periodCapture(periodCapture),
  .pulseWidthCapture(pulseWidthCapture), .countingFlag(countingFlag)
);

// [tb/tb.sv]
// self-checking bench of the measurement timer control block: registers,
// source selection, counting, manual requests and the interrupt.
// assumes source pulses of several cycles pass the 2-stage synchronisers.
`timescale 1ns/1ps

module tb;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic [8:0]  clkSrc    = '0;            // counter clock sources
  logic [23:0] winSrc    = '0;            // window sources
  logic [20:0] sigSrc    = '0;            // signal sources
  logic        sleepMode = 1'b0;
  logic [11:0] awAddr    = '0;
  logic [11:0] arAddr    = '0;
  logic [31:0] wData     = '0;
  logic        awValid   = 1'b0;
  logic        wValid    = 1'b0;
  logic        bReady    = 1'b0;
  logic        arValid   = 1'b0;
  logic        rReady    = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, irq;
  logic        cntFlag, winFlag, acqFlag;
  logic [1:0]  bResp, rResp, rdResp;
  logic [31:0] rData, rdVal;
  logic [23:0] cnt, perCap, pulCap;
  logic [31:0] lfsr      = 32'h5ad6043d;  // fixed seed keeps runs repeatable
  int          n_errors  = 0;
  int          num_checks = 0;
  int          n;

  always #12.5 clk = ~clk;

  smt_ctrl dut_u (
    .clk(clk), .rst(rst), .clockSources(clkSrc), .windowSources(winSrc),
    .signalSources(sigSrc), .sleepMode(sleepMode),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .measureCounter(cnt), .periodCapture(perCap), .pulseWidthCapture(pulCap),
    .countingFlag(cntFlag), .windowOpenFlag(winFlag), .acquisitionActiveFlag(acqFlag),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next random word from a galois shift register
  function automatic logic [31:0] rnd_next(input logic [31:0] v);
    rnd_next = {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
  endfunction : rnd_next

  // whether a selected source reaches the logic; reserved codes never do
  function automatic int live(input int k, input int c, input logic slp);
    if (k == 0) live = c < 9 && (!slp || (c >= 2 && c <= 7));
    else if (k == 1) live = c < 21 && !slp;
    else live = c < 24 && (!slp || (c >= 1 && c <= 4));
  endfunction : live

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task stop_test;
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  // bus write: both channels offered together, each released once taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!bValid);
    chk("bresp", bResp, smt_pkg::RESP_OKAY);
    bReady <= 1'b0;
    @(posedge clk);  // side effects land
  endtask : wr

  // bus read: data and response taken at the rvalid edge
  task rd(input logic [11:0] a);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!rValid);
    rdVal = rData;
    rdResp = rResp;
    rReady <= 1'b0;
  endtask : rd

  // selected source only; a reserved code toggles every source at once
  task drv(input int k, input int c, input logic on);
    logic [23:0] p;
    p = (c < (k == 0 ? 9 : k == 1 ? 21 : 24)) ? 24'h000001 << c : 24'hffffff;
    if (!on) p = '0;
    case (k)
      0: clkSrc <= p[8:0];
      1: sigSrc <= p[20:0];
      default: winSrc <= p;
    endcase
  endtask : drv

  // clean rises, wide enough for the synchronisers
  task pulse(input int k, input int c, input int num);
    repeat (num) begin
      @(posedge clk);
      drv(k, c, 1'b1);
      repeat (4) @(posedge clk);
      drv(k, c, 1'b0);
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : pulse

  // clear the counter, send a random number of rises, read the count back
  task count_run(input int k, input int c, input logic slp);
    wr(k ? 12'hc40 : 12'hc3c, c);
    sleepMode <= slp;
    wr(12'hc38, 32'h10);
    lfsr = rnd_next(lfsr);
    n = 1 + lfsr[1:0];
    pulse(k, c, n);
    rd(12'hc90);
    chk("counter", rdVal, live(k, c, slp) ? n : 0);
  endtask : count_run

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(12'hc38);
    chk("status rst", rdVal, 32'h0);
    rd(12'hc34);
    chk("control rst", rdVal, 32'h0);
    rd(12'hffc);
    chk("unmapped resp", rdResp, smt_pkg::RESP_SLVERR);
    chk("unmapped", rdVal, 32'h0);
    for (int m = 0; m < 16; m++) begin
      wr(12'hc34, 32'hc0 | m);
      repeat (4) @(posedge clk);
      chk("acq flag", acqFlag, m < 11);
      rd(12'hc34);
      if (m < 11) chk("control", rdVal, 32'hc0 | m);
    end
    wr(12'hc34, 32'hc0);
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 16; c++) count_run(0, c, s[0]);
    wr(12'hc34, 32'hc8);
    for (int c = 0; c < 32; c++) count_run(1, c, 1'b0);
    // frozen counter, then the three manual requests
    wr(12'hc40, 32'h0);
    wr(12'hc38, 32'h10);
    pulse(1, 0, n);
    wr(12'hc34, 32'h48);
    pulse(1, 0, 2);
    chk("go off", cnt, n);
    wr(12'hc38, 32'h80);
    chk("period cap", perCap, n);
    wr(12'hc38, 32'h40);
    chk("pulse cap", pulCap, n);
    wr(12'hc38, 32'h10);
    chk("cnt cleared", cnt, 32'h0);
    rd(12'hc38);
    chk("requests low", rdVal & 32'hd0, 32'h0);
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 32; c++) begin
        wr(12'hc44, c);
        sleepMode <= s[0];
        pulse(2, c, 0);
        drv(2, c, 1'b1);
        repeat (6) @(posedge clk);
        chk("win flag", winFlag, live(2, c, s[0]));
        rd(12'hc38);
        chk("win bit", rdVal[1], live(2, c, s[0]));
        drv(2, c, 1'b0);
        repeat (6) @(posedge clk);
        chk("win low", winFlag, 1'b0);
      end
    // single acquisition ends after one window; event masked, then raised
    sleepMode <= 1'b0;
    wr(12'hc80, 32'h7);
    wr(12'hc44, 32'h1);
    wr(12'hc34, 32'h84);
    pulse(2, 1, 1);
    rd(12'hc80);
    chk("events", rdVal, 32'h5);
    chk("single done", acqFlag, 1'b0);
    chk("irq masked", irq, 1'b0);
    wr(12'hc84, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq raised", irq, 1'b1);
    wr(12'hc80, 32'h7);
    repeat (3) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    rd(12'hc80);
    chk("events clear", rdVal, 32'h0);
    stop_test;
  end

  // hang guard, well beyond the expected run of some four thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule : tb
